// File: src/tcsa_alarm.sv
// tcsa_alarm: local alarm lamp latch with automatic or manual release.
// assumes red alarm and clear inputs are synchronous to mclk.
`timescale 1ns/1ps
module tcsa_alarm (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // control
    input  wire logic red_alarm,
    input  wire logic auto_release,
    input  wire logic alarm_clear,
    // lamp
    output logic      lamp_q
);
    // a new red alarm wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lamp_q <= 1'b0;
        end else if (red_alarm) begin
            lamp_q <= 1'b1;
        end else if (auto_release || alarm_clear) begin
            lamp_q <= 1'b0;
        end
    end

    chk_alarm_follows: assert property (@(posedge mclk) disable iff (!nrst)
        red_alarm |=> lamp_q)
        else $error("local alarm lamp not lit after red alarm");
    chk_auto_release: assert property (@(posedge mclk) disable iff (!nrst)
        (!red_alarm && auto_release) |=> !lamp_q)
        else $error("local alarm lamp not released automatically");
    chk_manual_latch: assert property (@(posedge mclk) disable iff (!nrst)
        (lamp_q && !red_alarm && !auto_release && !alarm_clear) |=> lamp_q)
        else $error("local alarm lamp dropped without clear");
endmodule

// File: src/tcsa_pkg.sv
// tcsa_pkg: constants and types for the line card status and alarm lamp logic.
// assumes a single 20 MHz clock domain; all other files reference names as tcsa_pkg::name.
package tcsa_pkg;

    // clock and lamp timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned SELFTEST_MIN_MS = 2000;
    localparam int unsigned SELFTEST_MAX_MS = 5000;
    localparam int unsigned BLINK_HALF_MS   = 250;
    localparam int unsigned BLINK_COUNT     = 3;
    localparam int unsigned SELFTEST_MIN_CYC = (CLK_HZ / 1000) * SELFTEST_MIN_MS;
    localparam int unsigned SELFTEST_MAX_CYC = (CLK_HZ / 1000) * SELFTEST_MAX_MS;
    localparam int unsigned BLINK_HALF_CYC   = (CLK_HZ / 1000) * BLINK_HALF_MS;

    // reset values
    localparam logic RST_AUTO_RELEASE = 1'b1;
    localparam logic RST_SLOT_EN      = 1'b0;

    // status lamp sequencer, gray along the normal path
    typedef enum logic [2:0] {
        TCSA_ST_TEST  = 3'b000,
        TCSA_ST_BLINK = 3'b001,
        TCSA_ST_READY = 3'b011,
        TCSA_ST_ACTV  = 3'b010,
        TCSA_ST_FAIL  = 3'b110
    } tcsa_state_t;

endpackage

// File: src/tcsa_tick_if.sv
// tcsa_tick_if: timer request and done strobe between the sequencer and its timer.
// assumes both ends share mclk.
`timescale 1ns/1ps
interface tcsa_tick_if;
    logic        start;
    logic [31:0] load;
    logic        done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

// File: src/tcsa_timer.sv
// tcsa_timer: one-shot down counter; start loads a cycle count, done pulses at expiry.
// assumes load is at least one; restart while running reloads.
`timescale 1ns/1ps
module tcsa_timer (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // request side
    tcsa_tick_if.tmr  tk
);
    logic [31:0] cnt_q;
    logic        run_q;

    // count down; done raised on the cycle the count reaches one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h0000_0000;
            run_q <= 1'b0;
        end else if (tk.start) begin
            cnt_q <= tk.load;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 32'h0000_0001;
            if (cnt_q == 32'h0000_0001) begin
                run_q <= 1'b0;
            end
        end
    end

    assign tk.done = run_q && (cnt_q == 32'h0000_0001);
endmodule

// File: src/tcsa_top.sv
// tcsa_top: faceplate lamp control for a two-slot T1 line card.
// assumes all inputs synchronous to mclk; slot enables come from the system controller.
`timescale 1ns/1ps
module tcsa_top #(
    parameter int unsigned SELFTEST_CYC = tcsa_pkg::SELFTEST_MIN_CYC,
    parameter int unsigned BLINK_CYC    = tcsa_pkg::BLINK_HALF_CYC,
    parameter int unsigned BLINKS       = tcsa_pkg::BLINK_COUNT
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // self-test and configuration
    input  wire logic selftest_done,
    input  wire logic selftest_pass,
    input  wire logic configured,
    // slot control from the system controller
    input  wire logic slot_main_en,
    input  wire logic slot_main_dis,
    input  wire logic slot_dtr_en,
    input  wire logic slot_dtr_dis,
    // link alarms
    input  wire logic red_alarm,
    input  wire logic yellow_rx,
    // operator console
    input  wire logic auto_release_set,
    input  wire logic auto_release_clr,
    input  wire logic alarm_clear,
    input  wire logic console_test,
    input  wire logic console_alarm_off,
    // lamps, link request and slot states
    output logic      status_lamp_q,
    output logic      local_alarm_lamp_q,
    output logic      far_end_alarm_lamp_q,
    output logic      test_active_lamp_q,
    output logic      yellow_tx_q,
    output logic      slot_main_q,
    output logic      slot_dtr_q
);
    // the blink counter is four bits wide, so eight flashes would fit; the check allows at most seven
    if (SELFTEST_CYC < 1 || BLINK_CYC < 1 || BLINKS < 1 || BLINKS > 7) begin : g_bad_param
        $error("tcsa_top: timing parameters out of range");
    end

    tcsa_pkg::tcsa_state_t st_q;
    logic                  auto_rel_q;
    logic [3:0]            blink_cnt_q;
    logic                  test_min_q;
    logic                  enabled;
    logic                  any_en_d;

    tcsa_tick_if tk ();

    tcsa_timer u_timer (
        .mclk (mclk),
        .nrst (nrst),
        .tk   (tk)
    );

    // slot enables; disable wins only when no enable arrives with it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_main_q <= tcsa_pkg::RST_SLOT_EN;
            slot_dtr_q  <= tcsa_pkg::RST_SLOT_EN;
        end else begin
            if (slot_main_en) begin
                slot_main_q <= 1'b1;
            end else if (slot_main_dis) begin
                slot_main_q <= 1'b0;
            end
            if (slot_dtr_en) begin
                slot_dtr_q <= 1'b1;
            end else if (slot_dtr_dis) begin
                slot_dtr_q <= 1'b0;
            end
        end
    end

    // card counts as enabled when either slot is and configured is set; both slots dropping or configured falling disables it
    assign any_en_d = (slot_main_en || (slot_main_q && !slot_main_dis))
                   || (slot_dtr_en || (slot_dtr_q && !slot_dtr_dis));
    assign enabled  = any_en_d && configured;

    // automatic release setting, on by default
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            auto_rel_q <= tcsa_pkg::RST_AUTO_RELEASE;
        end else if (auto_release_set) begin
            auto_rel_q <= 1'b1;
        end else if (auto_release_clr) begin
            auto_rel_q <= 1'b0;
        end
    end

    // timer requests: self-test window at reset release, half periods while blinking
    logic started_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end
    // the timer is idle once the self-test ends, so leaving it starts the first flash
    assign tk.start = !started_q
                   || (st_q == tcsa_pkg::TCSA_ST_TEST && selftest_done
                       && (test_min_q || tk.done))
                   || (st_q == tcsa_pkg::TCSA_ST_BLINK && tk.done);
    assign tk.load  = started_q ? 32'(BLINK_CYC) : 32'(SELFTEST_CYC);

    // self-test minimum lamp time; a shorter self-test still shows the full window
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            test_min_q <= 1'b0;
        end else if (st_q == tcsa_pkg::TCSA_ST_TEST && tk.done) begin
            test_min_q <= 1'b1;
        end
    end

    // status lamp sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q        <= tcsa_pkg::TCSA_ST_TEST;
            blink_cnt_q <= 4'h0;
        end else begin
            unique case (st_q)
                tcsa_pkg::TCSA_ST_TEST: begin
                    if (selftest_done && (test_min_q || tk.done)) begin
                        if (selftest_pass) begin
                            st_q <= tcsa_pkg::TCSA_ST_BLINK;
                        end else begin
                            st_q <= tcsa_pkg::TCSA_ST_FAIL;
                        end
                        blink_cnt_q <= 4'h0;
                    end
                end
                tcsa_pkg::TCSA_ST_BLINK: begin
                    if (tk.done) begin
                        blink_cnt_q <= blink_cnt_q + 4'h1;
                        if (blink_cnt_q == 4'(2 * BLINKS - 1)) begin
                            st_q <= tcsa_pkg::TCSA_ST_READY;
                        end
                    end
                end
                tcsa_pkg::TCSA_ST_READY: begin
                    if (enabled) begin
                        st_q <= tcsa_pkg::TCSA_ST_ACTV;
                    end
                end
                tcsa_pkg::TCSA_ST_ACTV: begin
                    if (!any_en_d || !configured) begin
                        st_q <= tcsa_pkg::TCSA_ST_READY;
                    end
                end
                tcsa_pkg::TCSA_ST_FAIL: begin
                    st_q <= tcsa_pkg::TCSA_ST_FAIL;
                end
                default: begin
                    st_q <= tcsa_pkg::TCSA_ST_FAIL;
                end
            endcase
        end
    end

    // lamp drive; even blink counts are the off halves of a flash
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_lamp_q <= 1'b1;
        end else begin
            unique case (st_q)
                tcsa_pkg::TCSA_ST_BLINK: status_lamp_q <= blink_cnt_q[0];
                tcsa_pkg::TCSA_ST_ACTV:  status_lamp_q <= 1'b0;
                default:                 status_lamp_q <= 1'b1;
            endcase
        end
    end

    // local alarm lamp with its latch
    tcsa_alarm u_alarm (
        .mclk         (mclk),
        .nrst         (nrst),
        .red_alarm    (red_alarm),
        .auto_release (auto_rel_q),
        .alarm_clear  (alarm_clear),
        .lamp_q       (local_alarm_lamp_q)
    );

    // yellow toward the far end follows the live red alarm, not the lamp latch
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            yellow_tx_q          <= 1'b0;
            far_end_alarm_lamp_q <= 1'b0;
            test_active_lamp_q   <= 1'b0;
        end else begin
            yellow_tx_q          <= red_alarm;
            far_end_alarm_lamp_q <= yellow_rx;
            test_active_lamp_q   <= console_test || console_alarm_off;
        end
    end

    // checks
    sequence s_pass_seen;
        st_q == tcsa_pkg::TCSA_ST_TEST && selftest_done && selftest_pass
            && (test_min_q || tk.done);
    endsequence
    sequence s_first_flash;
        (st_q == tcsa_pkg::TCSA_ST_BLINK) ##1 !status_lamp_q;
    endsequence
    sequence s_ready_lit;
        (st_q == tcsa_pkg::TCSA_ST_READY) ##1 status_lamp_q;
    endsequence

    // helper for the flash timing: cycles the lamp has held its present level
    logic        lamp_prev_q;
    logic [31:0] hold_cnt_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lamp_prev_q <= 1'b1;
            hold_cnt_q  <= 32'h0000_0000;
        end else begin
            lamp_prev_q <= status_lamp_q;
            if (status_lamp_q != lamp_prev_q) begin
                hold_cnt_q <= 32'h0000_0000;
            end else begin
                hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            end
        end
    end

    // self-test window and its outcome
    // an early done from the tester must not shorten the lit window
    chk_test_lit: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == tcsa_pkg::TCSA_ST_TEST |=> status_lamp_q)
        else $error("status lamp dark during self-test");
    chk_test_hold: assert property (@(posedge mclk) disable iff (!nrst)
        (st_q == tcsa_pkg::TCSA_ST_TEST && !test_min_q && !tk.done)
            |=> st_q == tcsa_pkg::TCSA_ST_TEST)
        else $error("self-test window ended early");
    chk_fail_lit: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == tcsa_pkg::TCSA_ST_FAIL |=> status_lamp_q)
        else $error("status lamp dark after self-test fail");
    chk_fail_final: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == tcsa_pkg::TCSA_ST_FAIL |=> st_q == tcsa_pkg::TCSA_ST_FAIL)
        else $error("failed card left the fail state");

    // flashes after a passed self-test
    chk_pass_blinks: assert property (@(posedge mclk) disable iff (!nrst)
        s_pass_seen |=> s_first_flash)
        else $error("no blink after self-test pass");
    chk_blink_half: assert property (@(posedge mclk) disable iff (!nrst)
        (st_q == tcsa_pkg::TCSA_ST_BLINK && status_lamp_q && !lamp_prev_q)
            |-> hold_cnt_q == 32'(BLINK_CYC - 1))
        else $error("dark half of a flash has the wrong length");
    chk_blink_end: assert property (@(posedge mclk) disable iff (!nrst)
        (st_q == tcsa_pkg::TCSA_ST_BLINK && tk.done && blink_cnt_q == 4'(2 * BLINKS - 1))
            |=> s_ready_lit)
        else $error("lamp not steady after the last flash");

    // slot state and the shared status lamp
    // either slot alone keeps a configured card active, so only both dropping or configured falling relights it
    chk_slot_main_on: assert property (@(posedge mclk) disable iff (!nrst)
        slot_main_en |=> slot_main_q)
        else $error("main slot not enabled");
    chk_slot_dtr_on: assert property (@(posedge mclk) disable iff (!nrst)
        slot_dtr_en |=> slot_dtr_q)
        else $error("daughter slot not enabled");
    chk_slot_main_off: assert property (@(posedge mclk) disable iff (!nrst)
        (slot_main_dis && !slot_main_en) |=> !slot_main_q)
        else $error("main slot not disabled");
    chk_slot_dtr_off: assert property (@(posedge mclk) disable iff (!nrst)
        (slot_dtr_dis && !slot_dtr_en) |=> !slot_dtr_q)
        else $error("daughter slot not disabled");
    chk_enable_off: assert property (@(posedge mclk) disable iff (!nrst)
        (st_q == tcsa_pkg::TCSA_ST_READY && enabled) |=> ##1 !status_lamp_q)
        else $error("status lamp not off after enable");
    chk_active_dark: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == tcsa_pkg::TCSA_ST_ACTV |=> !status_lamp_q)
        else $error("status lamp lit while active");
    chk_ready_lit: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == tcsa_pkg::TCSA_ST_READY |=> status_lamp_q)
        else $error("status lamp dark while not active");
    chk_one_slot_off: assert property (@(posedge mclk) disable iff (!nrst)
        (st_q == tcsa_pkg::TCSA_ST_ACTV && configured && any_en_d)
            |=> st_q == tcsa_pkg::TCSA_ST_ACTV)
        else $error("status lamp relit with a slot still enabled");
    chk_both_off: assert property (@(posedge mclk) disable iff (!nrst)
        (st_q == tcsa_pkg::TCSA_ST_ACTV && !any_en_d) |=> s_ready_lit)
        else $error("status lamp not relit after both slots dropped");

    // link alarms and console
    chk_yellow_tx: assert property (@(posedge mclk) disable iff (!nrst)
        red_alarm |=> yellow_tx_q)
        else $error("yellow not sent during red alarm");
    chk_yellow_stop: assert property (@(posedge mclk) disable iff (!nrst)
        !red_alarm |=> !yellow_tx_q)
        else $error("yellow still sent after red alarm ended");
    chk_far_lamp: assert property (@(posedge mclk) disable iff (!nrst)
        far_end_alarm_lamp_q == $past(yellow_rx) || $past(!nrst))
        else $error("far-end lamp does not follow yellow");
    chk_test_lamp: assert property (@(posedge mclk) disable iff (!nrst)
        !(console_test || console_alarm_off) |=> !test_active_lamp_q)
        else $error("test lamp stays lit");
    chk_test_on: assert property (@(posedge mclk) disable iff (!nrst)
        (console_test || console_alarm_off) |=> test_active_lamp_q)
        else $error("test lamp dark during console test");
endmodule

// File: tb/tcsa_partner.sv
// tcsa_partner: system controller slot pulses and t1 receiver alarm levels.
// assumes callers enter its tasks just after a rising edge of mclk.
`timescale 1ns/1ps
module tcsa_partner (
    // clock
    input  wire logic mclk,
    // slot pulses toward the card
    output logic      slot_main_en,
    output logic      slot_main_dis,
    output logic      slot_dtr_en,
    output logic      slot_dtr_dis,
    // link receiver levels
    output logic      red_alarm,
    output logic      yellow_rx
);
    // everything idle from time zero
    initial begin
        {slot_main_en, slot_main_dis, slot_dtr_en, slot_dtr_dis} = 4'h0;
        {red_alarm, yellow_rx} = 2'h0;
    end

    // one-cycle pulse, order {main_en, main_dis, dtr_en, dtr_dis}
    task automatic pulse(input logic [3:0] which);
        {slot_main_en, slot_main_dis, slot_dtr_en, slot_dtr_dis} = which;
        @(posedge mclk);
        #1;
        {slot_main_en, slot_main_dis, slot_dtr_en, slot_dtr_dis} = 4'h0;
    endtask

    // a real controller enables both slots to bring the whole card up
    task automatic enable_card();
        pulse(4'hA);
    endtask

    // levels seen on the received link
    task automatic set_link(input logic red, input logic ylw);
        red_alarm = red;
        yellow_rx = ylw;
    endtask
endmodule

// File: tb/tcsa_tb_top.sv
// tcsa_tb_top: self-checking bench for the faceplate lamp logic.
// assumes short timer parameters; outputs packed {status,local,far,test,ytx,main,dtr}.
`timescale 1ns/1ps
module tcsa_tb_top;
    typedef struct {int due; logic [6:0] mask; logic [6:0] exp;} tcsa_note_t;
    logic        mclk, nrst, st_done, st_pass, cfg, ar_set, ar_clr, a_clr, c_test, c_aoff;
    logic        sm_en, sm_dis, sd_en, sd_dis, red, ylw;
    logic        status, local_l, far, test_l, ytx, s_main, s_dtr;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;
    logic [31:0] rnd = 32'hE695;
    tcsa_note_t  notes[$];
    wire  [6:0]  outs = {status, local_l, far, test_l, ytx, s_main, s_dtr};

    tcsa_top #(.SELFTEST_CYC(20), .BLINK_CYC(4), .BLINKS(3)) dut (
        .mclk(mclk), .nrst(nrst), .selftest_done(st_done), .selftest_pass(st_pass),
        .configured(cfg), .slot_main_en(sm_en), .slot_main_dis(sm_dis),
        .slot_dtr_en(sd_en), .slot_dtr_dis(sd_dis), .red_alarm(red), .yellow_rx(ylw),
        .auto_release_set(ar_set), .auto_release_clr(ar_clr), .alarm_clear(a_clr),
        .console_test(c_test), .console_alarm_off(c_aoff), .status_lamp_q(status),
        .local_alarm_lamp_q(local_l), .far_end_alarm_lamp_q(far),
        .test_active_lamp_q(test_l), .yellow_tx_q(ytx), .slot_main_q(s_main),
        .slot_dtr_q(s_dtr));
    tcsa_partner partner (.mclk(mclk), .slot_main_en(sm_en), .slot_main_dis(sm_dis),
        .slot_dtr_en(sd_en), .slot_dtr_dis(sd_dis), .red_alarm(red), .yellow_rx(ylw));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic chk(input logic [6:0] got, input logic [6:0] exp, input logic [6:0] m,
                       input string msg);
        n_compared++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("wrong value at %0t: %s got %b exp %b", $time, msg, got, exp);
        end
    endtask
    task automatic note(input int d, input logic [6:0] m, input logic [6:0] e);
        notes.push_back('{cyc + d, m, e});
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // reset in mid-run too: lamps fall back to the self-test picture at once
    task automatic do_reset();
        nrst = 1'b0;
        tick(2);
        chk(outs, 7'h40, 7'h7F, "reset values");
        tick(2);
        nrst = 1'b1;
        repeat (20) begin
            chk(outs, 7'h40, 7'h40, "self-test lamp");
            tick(1);
        end
    endtask
    task automatic slot_step(input logic [3:0] which, input logic [6:0] exp);
        note(2, 7'h43, exp);
        partner.pulse(which);
        tick(3);
    endtask
    // random link and console levels against a lamp latch model
    task automatic rand_run(input int n, input logic auto, input logic [6:0] m);
        logic       lat;
        logic [6:0] ex;
        lat = 1'b0;
        repeat (n) begin
            rnd = lfsr(rnd);
            partner.set_link(rnd[0] & rnd[1], rnd[2]);
            c_test = rnd[3] & rnd[4];
            c_aoff = rnd[5] & rnd[6];
            a_clr = ~auto & rnd[7] & rnd[8];
            lat = red | (~auto & lat & ~a_clr);
            ex  = {1'b0, lat, ylw, c_test | c_aoff, red, 2'h3};
            note(1, m, ex);
            tick(1);
        end
        partner.set_link(1'b0, 1'b0);
        {c_test, c_aoff, a_clr} = 3'h0;
        tick(2);
    endtask

    // clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // cycle count and hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // result watcher: oldest due note is compared when its cycle settles
    always @(negedge mclk) begin
        while (notes.size() > 0 && notes[0].due == cyc) begin
            chk(outs, notes[0].exp, notes[0].mask, "queued result");
            void'(notes.pop_front());
        end
    end

    // main sequence
    initial begin : main_seq
        int rises;
        logic prev;
        // self-test reports done and pass at once; card starts unconfigured
        {nrst, st_done, st_pass, cfg, ar_set, ar_clr, a_clr, c_test, c_aoff} = 9'h0C0;
        do_reset();
        rises = 0;
        repeat (40) if (status !== 1'b0) tick(1);
        chk({6'h0, status}, 7'h00, 7'h01, "blink start");
        prev = status;
        repeat (30) begin
            tick(1);
            if (status === 1'b1 && prev === 1'b0) rises++;
            prev = status;
        end
        chk(7'(rises), 7'h03, 7'h7F, "blink count");
        chk(outs, 7'h40, 7'h40, "steady after blinks");
        $display("test selftest done");
        slot_step(4'h8, 7'h42);
        slot_step(4'h4, 7'h40);
        cfg = 1'b1;
        slot_step(4'h8, 7'h02);
        slot_step(4'h2, 7'h03);
        slot_step(4'h4, 7'h01);
        slot_step(4'h1, 7'h40);
        note(2, 7'h43, 7'h03);
        partner.enable_card();
        tick(3);
        $display("test slots done");
        rand_run(60, 1'b1, 7'h7F);
        ar_clr = 1'b1;
        tick(1);
        ar_clr = 1'b0;
        tick(1);
        rand_run(80, 1'b0, 7'h7F);
        $display("test alarms done");
        st_pass = 1'b0;
        do_reset();
        rand_run(40, 1'b1, 7'h3C);
        slot_step(4'hA, 7'h43);
        {ar_set, ar_clr} = 2'h3; // set wins, so release must stay automatic
        tick(1);
        {ar_set, ar_clr} = 2'h0;
        rand_run(20, 1'b1, 7'h3C);
        $display("test failed card done");
        report_and_stop();
    end
endmodule
